// file: src/mcr_config_pair.v
// motor configuration register pair: two words on the register port,
// decoded fields, tachometer pulse shaping and advance scaling
// assumes register port strobes and core status come from clk's domain
//
// Operation
// [RULE1] dither code 0 off; codes 1,2,3 give 5, 10, 15 percent
// [RULE2] tach policy 0 pulses always; 2 closed loop plus first open loop; 3 reserved
// [RULE3] tach policy 1 pulses only in closed loop after about 280 ms
// [RULE4] tach output frequency is electrical speed divided by divider plus one
// [RULE5] phase resistance code is resistance mantissa shifted left by its shift
// [RULE6] host splits resistance over 0.009615 into mantissa and shift
// [RULE7] bemf constant is its mantissa shifted left by its shift
// [RULE8] advance mode 0 keeps the programmed advance time fixed
// [RULE9] advance mode 1 scales advance by supply minus bemf over supply
// [RULE10] programmed advance time is advance mantissa shifted left by its shift
// [RULE11] top bit of advance word reads zero and ignores writes
// [RULE12] advance word at address 0x91, zero after reset
// [RULE13] electrical word at address 0x90, zero after reset
// [RULE14] written fields reach the core from the next cycle
`timescale 1ns/1ns
`default_nettype none
`include "mcr_defs.vh"

module mcr_config_pair #(
	parameter TACH_DELAY_CYCLES = `MCR_TACH_DELAY_CYC
) (
	// clock and reset
	input  wire                     clk,
	input  wire                     reset,
	// register port from the serial interface
	input  wire                     regWrite,
	input  wire                     regRead,
	input  wire [7:0]               regAddr,
	input  wire [15:0]              regWdata,
	output reg  [15:0]              regRdata,
	output reg                      regRdValid,
	// motor core status
	input  wire                     elecPulse,
	input  wire                     closedLoop,
	input  wire                     firstOpenLoop,
	input  wire [`MCR_VOLT_W-1:0]   supplyVolt,
	input  wire [`MCR_VOLT_W-1:0]   bemfVolt,
	// configuration to the motor core
	output reg  [1:0]               ditherSelect,
	output reg  [3:0]               ditherPercent,
	output reg                      clkCycleHalf,
	output reg  [`MCR_CODE_W-1:0]   phaseResCode,
	output reg  [`MCR_CODE_W-1:0]   bemfConstCode,
	output reg                      advanceModeBit,
	output reg  [`MCR_CODE_W-1:0]   advanceTimeSet,
	output reg  [`MCR_CODE_W-1:0]   advanceTimeApplied,
	// tachometer
	output reg                      tachOutput
);

	////////////////////////////////////////////////////////////////////
	// register words

	reg  [15:0] elecCfg_reg;
	reg  [15:0] elecCfg_next;
	reg  [15:0] advCfg_reg;
	reg  [15:0] advCfg_next;

	always @* begin
		elecCfg_next = elecCfg_reg;
		advCfg_next  = advCfg_reg;
		if (regWrite && regAddr == `MCR_ADDR_ELEC) begin // [RULE13]
			elecCfg_next = regWdata;
		end
		if (regWrite && regAddr == `MCR_ADDR_ADV) begin // [RULE12]
			advCfg_next = regWdata & `MCR_ADV_WMASK; // [RULE11]
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			elecCfg_reg <= `MCR_ELEC_RESET; // [RULE13]
			advCfg_reg  <= `MCR_ADV_RESET; // [RULE12]
			regRdata    <= 16'h0000;
			regRdValid  <= 1'b0;
		end else begin
			elecCfg_reg <= elecCfg_next;
			advCfg_reg  <= advCfg_next;
			regRdValid  <= regRead;
			if (regRead) begin
				// unmapped addresses answer zero
				case (regAddr)
					`MCR_ADDR_ELEC: regRdata <= elecCfg_reg;
					`MCR_ADDR_ADV:  regRdata <= advCfg_reg & `MCR_ADV_WMASK; // [RULE11]
					default:        regRdata <= 16'h0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// decoded fields, taken from the next value so a write shows at once, except tach policy and divider, taken from the register

	wire [1:0]  ditherNext = elecCfg_next[`MCR_DITHER_MSB:`MCR_DITHER_LSB];
	wire [2:0]  resShift   = elecCfg_next[`MCR_RSH_MSB:`MCR_RSH_LSB];
	wire [3:0]  resMan     = elecCfg_next[`MCR_RMAN_MSB:`MCR_RMAN_LSB];
	wire [2:0]  bemf_const_shift    = advCfg_next[`MCR_KSH_MSB:`MCR_KSH_LSB];
	wire [3:0]  ktMan      = advCfg_next[`MCR_KMAN_MSB:`MCR_KMAN_LSB];
	wire [2:0]  advShift   = advCfg_next[`MCR_ASH_MSB:`MCR_ASH_LSB];
	wire [3:0]  advMan     = advCfg_next[`MCR_AMAN_MSB:`MCR_AMAN_LSB];
	wire [1:0]  tachPolicy = elecCfg_reg[`MCR_TPOL_MSB:`MCR_TPOL_LSB];
	wire [3:0]  tachDiv    = elecCfg_reg[`MCR_TDIV_MSB:`MCR_TDIV_LSB];
	reg  [3:0]  pctNext;

	always @* begin
		case (ditherNext) // [RULE1]
			`MCR_DITHER_OFF: pctNext = `MCR_PCT_0;
			`MCR_DITHER_5:   pctNext = `MCR_PCT_5;
			`MCR_DITHER_10:  pctNext = `MCR_PCT_10;
			default:         pctNext = `MCR_PCT_15;
		endcase
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ditherSelect   <= 2'h0;
			ditherPercent  <= 4'h0;
			clkCycleHalf   <= 1'b0;
			phaseResCode   <= 11'h000;
			bemfConstCode  <= 11'h000;
			advanceModeBit <= 1'b0;
			advanceTimeSet <= 11'h000;
		end else begin
			ditherSelect   <= ditherNext; // [RULE14]
			ditherPercent  <= pctNext; // [RULE1]
			clkCycleHalf   <= elecCfg_next[`MCR_CLKADJ_BIT];
			phaseResCode   <= {7'h00, resMan} << resShift; // [RULE5]
			bemfConstCode  <= {7'h00, ktMan} << bemf_const_shift; // [RULE7]
			advanceModeBit <= advCfg_next[`MCR_AMODE_BIT];
			advanceTimeSet <= {7'h00, advMan} << advShift; // [RULE10]
		end
	end

	////////////////////////////////////////////////////////////////////
	// advance scaling: the divider reruns continuously, so the applied
	// value trails supply and bemf changes by 23 to 44 cycles

	wire [`MCR_VOLT_W-1:0]  voltDiff;
	wire [`MCR_NUM_W-1:0]   divNum;
	wire [`MCR_NUM_W-1:0]   divQuo;
	wire                    divBusy;
	wire                    divDone;
	reg  [`MCR_CODE_W-1:0]  scaledAdv_reg;

	// bemf above a nonzero supply clamps to zero advance
	assign voltDiff = (bemfVolt > supplyVolt) ? {`MCR_VOLT_W{1'b0}} : (supplyVolt - bemfVolt);
	assign divNum   = advanceTimeSet * voltDiff;

	mcr_adv_div uDiv (
		.clk         (clk),
		.reset       (reset),
		.start       (!divBusy),
		.numerator   (divNum),
		.denominator (supplyVolt),
		.busy        (divBusy),
		.done        (divDone),
		.quotient    (divQuo)
	);

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			scaledAdv_reg      <= 11'h000;
			advanceTimeApplied <= 11'h000;
		end else begin
			if (divDone) begin
				// zero supply gives all ones, clamp to the setting
				if (divQuo > {10'h000, advanceTimeSet}) begin
					scaledAdv_reg <= advanceTimeSet;
				end else begin
					scaledAdv_reg <= divQuo[`MCR_CODE_W-1:0];
				end
			end
			if (advanceModeBit) begin
				advanceTimeApplied <= scaledAdv_reg; // [RULE9]
			end else begin
				advanceTimeApplied <= advanceTimeSet; // [RULE8]
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// tachometer

	reg  [24:0] loopDelayCnt;
	reg         loopDelayDone;
	reg  [3:0]  poleCnt;
	reg         tachEnable;

	always @* begin
		case (tachPolicy)
			`MCR_TPOL_CLOSED_DLY: tachEnable = closedLoop && loopDelayDone; // [RULE3]
			`MCR_TPOL_FIRST_OPEN: tachEnable = closedLoop || firstOpenLoop; // [RULE2]
			default:              tachEnable = 1'b1; // [RULE2]
		endcase
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			loopDelayCnt  <= 25'h000_0000;
			loopDelayDone <= 1'b0;
			poleCnt       <= 4'h0;
			tachOutput    <= 1'b0;
		end else begin
			// delay restarts whenever closed loop is lost
			if (!closedLoop) begin
				loopDelayCnt  <= 25'h000_0000;
				loopDelayDone <= 1'b0;
			end else if (!loopDelayDone) begin
				if (loopDelayCnt >= TACH_DELAY_CYCLES[24:0] - 25'h000_0001) begin
					loopDelayDone <= 1'b1; // [RULE3]
				end
				loopDelayCnt <= loopDelayCnt + 25'h000_0001;
			end
			tachOutput <= 1'b0;
			if (elecPulse) begin
				if (poleCnt >= tachDiv) begin // [RULE4]
					poleCnt    <= 4'h0;
					tachOutput <= tachEnable;
				end else begin
					poleCnt <= poleCnt + 4'h1;
				end
			end
		end
	end

endmodule // mcr_config_pair
`default_nettype wire

// file: src/mcr_defs.vh
// constants of the motor configuration register pair
// assumes inclusion by bare name from the design files
`ifndef MCR_DEFS_VH
`define MCR_DEFS_VH

// register addresses on the serial register port
`define MCR_ADDR_ELEC         8'h90
`define MCR_ADDR_ADV          8'h91

// reset values
`define MCR_ELEC_RESET        16'h0000
`define MCR_ADV_RESET         16'h0000

// write mask of the advance word, top bit is reserved
`define MCR_ADV_WMASK         16'h7FFF

// electrical word fields
`define MCR_DITHER_MSB        15
`define MCR_DITHER_LSB        14
`define MCR_TPOL_MSB          13
`define MCR_TPOL_LSB          12
`define MCR_TDIV_MSB          11
`define MCR_TDIV_LSB          8
`define MCR_CLKADJ_BIT        7
`define MCR_RSH_MSB           6
`define MCR_RSH_LSB           4
`define MCR_RMAN_MSB          3
`define MCR_RMAN_LSB          0

// advance word fields
`define MCR_KSH_MSB           14
`define MCR_KSH_LSB           12
`define MCR_KMAN_MSB          11
`define MCR_KMAN_LSB          8
`define MCR_AMODE_BIT         7
`define MCR_ASH_MSB           6
`define MCR_ASH_LSB           4
`define MCR_AMAN_MSB          3
`define MCR_AMAN_LSB          0

// dithering codes and their amplitude in percent
`define MCR_DITHER_OFF        2'h0
`define MCR_DITHER_5          2'h1
`define MCR_DITHER_10         2'h2
`define MCR_DITHER_15         2'h3
`define MCR_PCT_0             4'h0
`define MCR_PCT_5             4'h5
`define MCR_PCT_10            4'hA
`define MCR_PCT_15            4'hF

// tachometer policy codes
`define MCR_TPOL_BOTH         2'h0
`define MCR_TPOL_CLOSED_DLY   2'h1
`define MCR_TPOL_FIRST_OPEN   2'h2
`define MCR_TPOL_RSVD         2'h3

// closed-loop tachometer delay
`define MCR_CLK_MHZ           100
`define MCR_TACH_DELAY_MS     280
`define MCR_TACH_DELAY_CYC    (`MCR_TACH_DELAY_MS * 1000 * `MCR_CLK_MHZ)

// divider sizes
`define MCR_VOLT_W            10
`define MCR_NUM_W             21
`define MCR_CODE_W            11
// last bit step of the divider, one per numerator bit
`define MCR_DIV_LAST          5'h14

`endif

// file: src/mcr_adv_div.v
// restoring divider for the scaled commutation advance
// assumes start is only raised while idle, one clock domain
`timescale 1ns/1ns
`default_nettype none
`include "mcr_defs.vh"

module mcr_adv_div (
	// clock and reset
	input  wire                     clk,
	input  wire                     reset,
	// request
	input  wire                     start,
	input  wire [`MCR_NUM_W-1:0]    numerator,
	input  wire [`MCR_VOLT_W-1:0]   denominator,
	// answer
	output reg                      busy,
	output reg                      done,
	output reg  [`MCR_NUM_W-1:0]    quotient
);

	reg [`MCR_NUM_W-1:0]    numReg;
	reg [`MCR_VOLT_W:0]     remReg;
	reg [`MCR_VOLT_W-1:0]   denReg;
	reg [4:0]               bitCnt;
	wire [`MCR_VOLT_W:0]    remShift;
	wire [`MCR_VOLT_W:0]    remSub;

	assign remShift = {remReg[`MCR_VOLT_W-1:0], numReg[`MCR_NUM_W-1]};
	assign remSub   = remShift - {1'b0, denReg};

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			busy     <= 1'b0;
			done     <= 1'b0;
			quotient <= {`MCR_NUM_W{1'b0}};
			numReg   <= {`MCR_NUM_W{1'b0}};
			remReg   <= {(`MCR_VOLT_W+1){1'b0}};
			denReg   <= {`MCR_VOLT_W{1'b0}};
			bitCnt   <= 5'h00;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				busy   <= 1'b1;
				numReg <= numerator;
				denReg <= denominator;
				remReg <= {(`MCR_VOLT_W+1){1'b0}};
				bitCnt <= 5'h00;
			end else if (busy) begin
				// quotient bits shift in where numerator bits leave
				if (remShift >= {1'b0, denReg}) begin
					remReg <= remSub;
					numReg <= {numReg[`MCR_NUM_W-2:0], 1'b1};
				end else begin
					remReg <= remShift;
					numReg <= {numReg[`MCR_NUM_W-2:0], 1'b0};
				end
				if (bitCnt == `MCR_DIV_LAST) begin
					busy     <= 1'b0;
					done     <= 1'b1;
					quotient <= (remShift >= {1'b0, denReg}) ?
						{numReg[`MCR_NUM_W-2:0], 1'b1} : {numReg[`MCR_NUM_W-2:0], 1'b0};
				end
				bitCnt <= bitCnt + 5'h01;
			end
		end
	end

endmodule // mcr_adv_div
`default_nettype wire

// file: sim/mcr_config_pair_monitor.sv
// checker for the motor configuration register pair
// assumes it is bound onto mcr_config_pair, one clock domain
`timescale 1ns/1ns
`default_nettype none
`include "mcr_defs.vh"
module mcr_config_pair_monitor (
	// clock and reset
	input wire logic                   clk,
	input wire logic                   reset,
	// register port
	input wire logic                   regWrite,
	input wire logic                   regRead,
	input wire logic [7:0]             regAddr,
	input wire logic [15:0]            regWdata,
	input wire logic [15:0]            regRdata,
	input wire logic                   regRdValid,
	// core side
	input wire logic                   elecPulse,
	input wire logic [1:0]             ditherSelect,
	input wire logic [3:0]             ditherPercent,
	input wire logic [`MCR_CODE_W-1:0] phaseResCode,
	input wire logic [`MCR_CODE_W-1:0] bemfConstCode,
	input wire logic                   advanceModeBit,
	input wire logic [`MCR_CODE_W-1:0] advanceTimeSet,
	input wire logic [`MCR_CODE_W-1:0] advanceTimeApplied,
	input wire logic                   tachOutput
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence sWrElec; regWrite && regAddr == `MCR_ADDR_ELEC; endsequence
	sequence sWrAdv; regWrite && regAddr == `MCR_ADDR_ADV; endsequence
	// fields checked two edges on: holds whether fields are sliced or re-registered
	chk_read_answer: assert property (regRead |=> regRdValid)
		else $error("read not answered");
	chk_valid_cause: assert property (regRdValid |-> $past(regRead))
		else $error("read answer without request");
	chk_top_bit_zero: assert property (regRead && regAddr == `MCR_ADDR_ADV |=> !regRdata[15])
		else $error("reserved bit reads one");
	chk_dither_pct: assert property (sWrElec |-> ##2
		ditherSelect == $past(regWdata[15:14], 2)
		&& ditherPercent == {2'b00, ditherSelect} * 4'h5) else $error("dither wrong");
	chk_res_code: assert property (sWrElec |-> ##2 phaseResCode ==
		({7'h00, $past(regWdata[3:0], 2)} << $past(regWdata[6:4], 2))) else $error("res code");
	chk_bemf_code: assert property (sWrAdv |-> ##2 bemfConstCode ==
		({7'h00, $past(regWdata[11:8], 2)} << $past(regWdata[14:12], 2))) else $error("bemf code");
	chk_adv_set: assert property (sWrAdv |-> ##2 advanceModeBit == $past(regWdata[7], 2)
		&& advanceTimeSet == ({7'h00, $past(regWdata[3:0], 2)} << $past(regWdata[6:4], 2)))
		else $error("advance setting");
	chk_mode_fixed: assert property ((!advanceModeBit) [*2] |->
		advanceTimeApplied == $past(advanceTimeSet)) else $error("fixed advance");
	chk_tach_cause: assert property (tachOutput |-> $past(elecPulse))
		else $error("tach pulse without cause");
endmodule // mcr_config_pair_monitor
`default_nettype wire

// file: sim/mcr_host_model.sv
// host on the register port: one-cycle strobes, resistance code split
// assumes the bench's clock; requests change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module mcr_host_model (
	// clock
	input  wire logic        clk,
	// register port
	output var  logic        regWrite,
	output var  logic        regRead,
	output var  logic [7:0]  regAddr,
	output var  logic [15:0] regWdata,
	input  wire logic [15:0] regRdata,
	input  wire logic        regRdValid
);
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 16'h0000;
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		regWrite = 1'b1;
		regAddr = a;
		regWdata = d;
		@(negedge clk);
		regWrite = 1'b0;
		regWdata = ~d; // stale data must not look valid
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
		@(negedge clk);
		regRead = 1'b1;
		regAddr = a;
		@(negedge clk);
		regRead = 1'b0;
		d = regRdata;
		v = regRdValid;
	endtask
	// keeps the top four bits, drops the rest
	function automatic logic [6:0] res_split(input logic [10:0] c);
		int s;
		s = 0;
		while ((c >> s) > 11'h00f) s++;
		return {s[2:0], c[s+:4]};
	endfunction
endmodule // mcr_host_model
`default_nettype wire

// file: sim/mcr_config_pair_tb.sv
// self-checking bench for the motor configuration register pair
// assumes a short closed-loop delay and the host model on the port
`timescale 1ns/1ns
`default_nettype none
`include "mcr_defs.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module mcr_config_pair_tb;
	// set at declaration so time zero shows no false falling edge
	logic clk = 1'b0;
	logic reset, regWrite, regRead, regRdValid, elecPulse, closedLoop, firstOpenLoop, vld;
	logic [7:0] regAddr;
	logic [15:0] regWdata, regRdata, rd;
	logic [9:0] supplyVolt, bemfVolt;
	logic [1:0] ditherSelect;
	logic [3:0] ditherPercent;
	logic clkCycleHalf, advanceModeBit, tachOutput;
	logic [10:0] phaseResCode, bemfConstCode, advanceTimeSet, advanceTimeApplied;
	int failures = 0, checked = 0, tachCnt = 0;
	mcr_config_pair #(.TACH_DELAY_CYCLES(20)) i_mcr_config_pair (.clk(clk), .reset(reset),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata), .regRdValid(regRdValid), .elecPulse(elecPulse),
		.closedLoop(closedLoop), .firstOpenLoop(firstOpenLoop), .supplyVolt(supplyVolt),
		.bemfVolt(bemfVolt), .ditherSelect(ditherSelect), .ditherPercent(ditherPercent),
		.clkCycleHalf(clkCycleHalf), .phaseResCode(phaseResCode), .bemfConstCode(bemfConstCode),
		.advanceModeBit(advanceModeBit), .advanceTimeSet(advanceTimeSet),
		.advanceTimeApplied(advanceTimeApplied), .tachOutput(tachOutput));
	mcr_host_model i_mcr_host_model (.clk(clk), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid));
	initial begin
		forever #5 clk = ~clk;
	end
	// counted on the falling edge, half a cycle after launch, where the pulse has settled
	always @(negedge clk) if (tachOutput === 1'b1) tachCnt++;
	task automatic test_done;
		if (failures == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic pulses(input int n, input int exp);
		int t0;
		t0 = tachCnt;
		repeat (n) begin
			@(negedge clk) elecPulse = 1'b1;
			@(negedge clk) elecPulse = 1'b0;
		end
		repeat (2) @(negedge clk);
		`CHK("tach count", exp, tachCnt - t0)
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		failures++; // hang cut short
		test_done;
	end
	initial begin
		reset = 1'b1;
		elecPulse = 1'b0;
		closedLoop = 1'b0;
		firstOpenLoop = 1'b0;
		supplyVolt = 10'h064;
		bemfVolt = 10'h019;
		repeat (3) @(negedge clk);
		reset = 1'b0;
		i_mcr_host_model.rd(`MCR_ADDR_ELEC, rd, vld);
		`CHK("elec reset", 16'h0000, rd)
		`CHK("read valid", 1'b1, vld)
		i_mcr_host_model.rd(`MCR_ADDR_ADV, rd, vld);
		`CHK("adv reset", 16'h0000, rd)
		for (int c = 0; c < 4; c++) begin
			// clock adjust bit rides along with the dither code
			i_mcr_host_model.wr(`MCR_ADDR_ELEC, {c[1:0], 6'h00, c[0], 7'h00});
			@(negedge clk);
			`CHK("dither", c[1:0], ditherSelect)
			`CHK("dither pct", 4'(c * 5), ditherPercent)
			`CHK("clk adjust", c[0], clkCycleHalf)
		end
		i_mcr_host_model.wr(8'h92, 16'hffff);
		i_mcr_host_model.rd(8'h92, rd, vld);
		`CHK("unmapped", 16'h0000, rd)
		// divider 2, policy 0, resistance code split by the host
		rd = {8'h02, 1'b0, i_mcr_host_model.res_split(11'h5a3)};
		i_mcr_host_model.wr(`MCR_ADDR_ELEC, rd);
		i_mcr_host_model.rd(`MCR_ADDR_ELEC, rd, vld);
		`CHK("elec word", 16'h027b, rd)
		`CHK("res code", 11'h580, phaseResCode)
		pulses(6, 2);
		i_mcr_host_model.wr(`MCR_ADDR_ELEC, 16'h127b);
		pulses(6, 0);
		closedLoop = 1'b1;
		repeat (25) @(negedge clk);
		pulses(6, 2);
		i_mcr_host_model.wr(`MCR_ADDR_ELEC, 16'h227b);
		closedLoop = 1'b0;
		pulses(6, 0);
		firstOpenLoop = 1'b1;
		pulses(6, 2);
		// reserved policy code pulses in open loop like code zero
		i_mcr_host_model.wr(`MCR_ADDR_ELEC, 16'h327b);
		firstOpenLoop = 1'b0;
		pulses(6, 2);
		i_mcr_host_model.wr(`MCR_ADDR_ADV, 16'hffff);
		i_mcr_host_model.rd(`MCR_ADDR_ADV, rd, vld);
		`CHK("adv word", 16'h7fff, rd)
		`CHK("bemf code", 11'h780, bemfConstCode)
		`CHK("adv set", 11'h780, advanceTimeSet)
		// scaled: 32 * (100 - 25) / 100
		i_mcr_host_model.wr(`MCR_ADDR_ADV, 16'h00a8);
		repeat (100) if (advanceTimeApplied !== 11'h018) @(negedge clk);
		`CHK("adv scaled", 11'h018, advanceTimeApplied)
		i_mcr_host_model.wr(`MCR_ADDR_ADV, 16'h0023);
		repeat (3) @(negedge clk);
		`CHK("adv fixed", 11'h00c, advanceTimeApplied)
		// reset in mid-run must clear both words again
		@(negedge clk) reset = 1'b1;
		@(negedge clk) reset = 1'b0;
		i_mcr_host_model.rd(`MCR_ADDR_ADV, rd, vld);
		`CHK("adv cleared", 16'h0000, rd)
		`CHK("set cleared", 11'h000, advanceTimeSet)
		i_mcr_host_model.rd(`MCR_ADDR_ELEC, rd, vld);
		`CHK("elec cleared", 16'h0000, rd)
		`CHK("res cleared", 11'h000, phaseResCode)
		test_done;
	end
endmodule // mcr_config_pair_tb
bind mcr_config_pair mcr_config_pair_monitor i_mcr_config_pair_monitor (.clk(clk), .reset(reset),
	.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
	.regRdata(regRdata), .regRdValid(regRdValid), .elecPulse(elecPulse),
	.ditherSelect(ditherSelect), .ditherPercent(ditherPercent), .phaseResCode(phaseResCode),
	.bemfConstCode(bemfConstCode), .advanceModeBit(advanceModeBit),
	.advanceTimeSet(advanceTimeSet), .advanceTimeApplied(advanceTimeApplied),
	.tachOutput(tachOutput));
`default_nettype wire
